// file: rtl/tlg_top.sv
// tlg_top: torque limit clamp and electronic gear with register port
// assumes synchronous inputs on mclk and a one-cycle strobe register master
//
// Contract
// - torque settings span 0..300, default 300 for ordinary pairings
// - listed pairings use their own maximum between 245 and 350
// - the pairing maximum bounds all five torque settings alike
// - a motor change re-derives the maximum; stored settings are clamped to it in hardware
// - gear numerator and denominator accepted from 1 to 2^30
// - excessive multiplication under varying pulses raises multiplication error
// - speed r/min equals frequency times ratio over counts per rev times 60
`timescale 1ns/1ps
module tlg_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // motor and commands
  input  wire logic [4:0]  motor_pair,
  input  wire logic        cmd_pulse,
  input  wire logic [9:0]  torque_req,
  // outputs
  output logic [9:0]       torque_cmd,
  output logic             enc_pulse,
  output logic             pulse_multiplication_error,
  output logic             irq
);
  logic [9:0]  first_torque_limit;
  logic [9:0]  second_torque_limit;
  logic [9:0]  emergency_stop_torque;
  logic [9:0]  ext_positive_torque_limit;
  logic [9:0]  ext_negative_torque_limit;
  logic [30:0] gear_numerator;
  logic [30:0] gear_denominator;
  logic [31:0] enc_counts;
  logic [2:0]  sel;
  logic [3:0]  status;
  logic [3:0]  mask;
  logic [9:0]  torque_max;
  logic [4:0]  pair_q;
  logic [31:0] sec_cnt;
  logic [31:0] pulse_cnt;
  logic [31:0] freq;
  logic [31:0] speed;
  logic [9:0]  next_tl [5];
  logic [9:0]  tl [5];
  logic [30:0] next_num;
  logic [30:0] next_den;
  logic [31:0] next_enc;
  logic [2:0]  next_sel;
  logic [3:0]  next_status;
  logic [3:0]  next_mask;
  logic [31:0] next_rdata;
  logic [31:0] next_sec_cnt;
  logic [31:0] next_pulse_cnt;
  logic [31:0] next_freq;
  logic [31:0] next_speed;
  logic [9:0]  next_torque_cmd;
  logic        next_err;
  logic        next_irq;
  logic [9:0]  active_lim;
  logic [9:0]  req_clamped;
  logic        req_hit;
  logic        gear_pulse;
  logic [15:0] enc_per_cmd;
  logic        mult_evt;
  logic        range_bad;
  logic [96:0] spd_prod;
  logic [96:0] spd_div;

  // pairing to torque maximum
  function automatic logic [9:0] pair_max(input logic [4:0] p);
    if (p == 5'h00) begin
      pair_max = tlg_pkg::TRQ_DEF_MAX;
    end else if (p <= 5'h0f) begin
      pair_max = tlg_pkg::TRQ_HI_MAX;
    end else if (p == 5'h10) begin
      pair_max = tlg_pkg::TRQ_P1;
    end else if (p == 5'h11) begin
      pair_max = tlg_pkg::TRQ_P2;
    end else if (p == 5'h12) begin
      pair_max = tlg_pkg::TRQ_P3;
    end else if (p == 5'h13) begin
      pair_max = tlg_pkg::TRQ_P4;
    end else if (p == 5'h14) begin
      pair_max = tlg_pkg::TRQ_P5;
    end else if (p == 5'h15) begin
      pair_max = tlg_pkg::TRQ_P6;
    end else begin
      pair_max = tlg_pkg::TRQ_DEF_MAX;
    end
  endfunction

  // bounds a written torque value against the current maximum
  function automatic logic [9:0] trq_bound(input logic [31:0] v, input logic [9:0] m);
    trq_bound = (v > {22'h000000, m}) ? m : v[9:0];
  endfunction

  function automatic logic [30:0] gear_bound(input logic [31:0] v);
    if (v < {1'h0, tlg_pkg::GEAR_MIN}) begin
      gear_bound = tlg_pkg::GEAR_MIN;
    end else if (v > {1'h0, tlg_pkg::GEAR_MAX}) begin
      gear_bound = tlg_pkg::GEAR_MAX;
    end else begin
      gear_bound = v[30:0];
    end
  endfunction

  assign torque_max = pair_max(pair_q);
  assign first_torque_limit = tl[0];
  assign second_torque_limit = tl[1];
  assign emergency_stop_torque = tl[2];
  assign ext_positive_torque_limit = tl[3];
  assign ext_negative_torque_limit = tl[4];

  always_comb begin
    case (sel)
      3'h1: active_lim = second_torque_limit;
      3'h2: active_lim = emergency_stop_torque;
      3'h3: active_lim = ext_positive_torque_limit;
      3'h4: active_lim = ext_negative_torque_limit;
      default: active_lim = first_torque_limit;
    endcase
  end

  tlg_clamp u_clamp (
    .value  (torque_req),
    .bound  (active_lim),
    .result (req_clamped),
    .hit    (req_hit)
  );

  tlg_gear u_gear (
    .mclk        (mclk),
    .reset       (reset),
    .num         (gear_numerator),
    .den         (gear_denominator),
    .cmd_pulse   (cmd_pulse),
    .enc_pulse   (gear_pulse),
    .enc_per_cmd (enc_per_cmd)
  );

  // too many encoder pulses emitted between command pulses
  assign mult_evt = cmd_pulse && ({16'h0000, enc_per_cmd} > tlg_pkg::MULT_ERR_RATE)
                    && (gear_numerator > gear_denominator);
  // ratio outside 1/1000..1000 flagged for software
  assign range_bad = ({35'h0, gear_numerator} > {34'h0, gear_denominator} * 31'd1000)
                  || ({35'h0, gear_denominator} > {34'h0, gear_numerator} * 31'd1000);
  assign spd_prod = {33'h0, freq} * {33'h0, 1'b0, gear_numerator} * {91'h0, tlg_pkg::SEC_PER_MIN};
  assign spd_div = {66'h0, gear_denominator} * {65'h0, enc_counts};

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      next_tl[i] = trq_bound({22'h000000, tl[i]}, torque_max);
      if (wr && addr == tlg_pkg::A_TLIM1 + 8'(4 * i)) begin
        next_tl[i] = trq_bound(wdata, torque_max);
      end
    end
  end

  // setting writes, status set and clear
  always_comb begin
    next_num = gear_numerator;
    next_den = gear_denominator;
    next_enc = enc_counts;
    next_sel = sel;
    next_mask = mask;
    next_status = status;
    if (wr && addr == tlg_pkg::A_GNUM) begin
      next_num = gear_bound(wdata);
    end else if (wr && addr == tlg_pkg::A_GDEN) begin
      next_den = gear_bound(wdata);
    end else if (wr && addr == tlg_pkg::A_SEL) begin
      next_sel = (wdata[2:0] > 3'h4) ? 3'h0 : wdata[2:0];
    end else if (wr && addr == tlg_pkg::A_MASK) begin
      next_mask = wdata[3:0];
    end else if (wr && addr == tlg_pkg::A_ENC) begin
      next_enc = (wdata == 32'h0) ? tlg_pkg::ENC_RST : wdata;
    end else if (wr && addr == tlg_pkg::A_STAT) begin
      next_status = status & ~wdata[3:0];
    end
    // set wins over clear
    if (mult_evt) next_status[tlg_pkg::ST_MULT] = 1'b1;
    if (range_bad) next_status[tlg_pkg::ST_RANGE] = 1'b1;
    if (req_hit) next_status[tlg_pkg::ST_CLAMP] = 1'b1;
    if (motor_pair != pair_q) next_status[tlg_pkg::ST_PAIR] = 1'b1;
    next_err = next_status[tlg_pkg::ST_MULT];
    next_irq = |(next_status & mask);
  end

  // one-second pulse frequency window and speed
  always_comb begin
    next_sec_cnt = sec_cnt + 32'h1;
    next_pulse_cnt = pulse_cnt + {31'h0, cmd_pulse};
    next_freq = freq;
    next_speed = speed;
    if (sec_cnt == tlg_pkg::ONE_SEC_CYC - 32'h1) begin
      next_sec_cnt = 32'h0;
      next_pulse_cnt = {31'h0, cmd_pulse};
      next_freq = pulse_cnt;
    end
    next_speed = 32'(spd_prod / spd_div);
  end

  // register read mux
  always_comb begin
    next_rdata = 32'h0;
    if (rd) begin
      if (addr <= tlg_pkg::A_TEXTN && addr[1:0] == 2'h0) begin
        next_rdata = {22'h0, tl[addr[4:2]]};
      end else if (addr == tlg_pkg::A_GNUM) begin
        next_rdata = {1'h0, gear_numerator};
      end else if (addr == tlg_pkg::A_GDEN) begin
        next_rdata = {1'h0, gear_denominator};
      end else if (addr == tlg_pkg::A_PAIR) begin
        next_rdata = {27'h0, pair_q};
      end else if (addr == tlg_pkg::A_SEL) begin
        next_rdata = {29'h0, sel};
      end else if (addr == tlg_pkg::A_STAT) begin
        next_rdata = {28'h0, status};
      end else if (addr == tlg_pkg::A_MASK) begin
        next_rdata = {28'h0, mask};
      end else if (addr == tlg_pkg::A_TMAX) begin
        next_rdata = {22'h0, torque_max};
      end else if (addr == tlg_pkg::A_FREQ) begin
        next_rdata = freq;
      end else if (addr == tlg_pkg::A_SPEED) begin
        next_rdata = speed;
      end else if (addr == tlg_pkg::A_ENC) begin
        next_rdata = enc_counts;
      end
    end
  end

  assign next_torque_cmd = req_clamped;

  // torque limit registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 5; i++) tl[i] <= tlg_pkg::TRQ_DEF_MAX;
    end else begin
      for (int i = 0; i < 5; i++) tl[i] <= next_tl[i];
    end
  end

  // frequency window and speed registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      sec_cnt <= 32'h0;
      pulse_cnt <= 32'h0;
      freq <= 32'h0;
      speed <= 32'h0;
    end else begin
      sec_cnt <= next_sec_cnt;
      pulse_cnt <= next_pulse_cnt;
      freq <= next_freq;
      speed <= next_speed;
    end
  end

  // settings, status and output registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      gear_numerator <= tlg_pkg::GEAR_RST;
      gear_denominator <= tlg_pkg::GEAR_RST;
      enc_counts <= tlg_pkg::ENC_RST;
      sel <= 3'h0;
      status <= 4'h0;
      mask <= 4'h0;
      pair_q <= 5'h00;
      rdata <= 32'h0;
      torque_cmd <= 10'h000;
      enc_pulse <= 1'b0;
      pulse_multiplication_error <= 1'b0;
      irq <= 1'b0;
    end else begin
      gear_numerator <= next_num;
      gear_denominator <= next_den;
      enc_counts <= next_enc;
      sel <= next_sel;
      status <= next_status;
      mask <= next_mask;
      pair_q <= motor_pair;
      rdata <= next_rdata;
      torque_cmd <= next_torque_cmd;
      enc_pulse <= gear_pulse;
      pulse_multiplication_error <= next_err;
      irq <= next_irq;
    end
  end
endmodule

// file: shared/tlg_pkg.sv
// tlg_pkg: constants for the torque limit clamp and electronic gear block
// assumes a single 40 MHz clock domain and a plain register port
package tlg_pkg;
  localparam int unsigned CLK_HZ      = 40000000;
  localparam logic [9:0]  TRQ_MIN     = 10'h000;
  localparam logic [9:0]  TRQ_DEF_MAX = 10'h12c;   // 300
  localparam logic [9:0]  TRQ_HI_MAX  = 10'h15e;   // 350
  localparam logic [9:0]  TRQ_P1      = 10'h108;   // 264
  localparam logic [9:0]  TRQ_P2      = 10'h119;   // 281
  localparam logic [9:0]  TRQ_P3      = 10'h0fb;   // 251
  localparam logic [9:0]  TRQ_P4      = 10'h128;   // 296
  localparam logic [9:0]  TRQ_P5      = 10'h0f5;   // 245
  localparam logic [9:0]  TRQ_P6      = 10'h0fa;   // 250
  localparam logic [30:0] GEAR_MIN    = 31'h00000001;
  localparam logic [30:0] GEAR_MAX    = 31'h40000000;  // 2^30
  localparam logic [15:0] RATIO_LIMIT = 16'h03e8;     // 1000
  localparam logic [5:0]  SEC_PER_MIN = 6'h3c;        // 60
  localparam logic [31:0] MULT_ERR_RATE = 32'h00000004;  // output pulses per input pulse limit
  // register offsets
  localparam logic [7:0] A_TLIM1   = 8'h00;
  localparam logic [7:0] A_TLIM2   = 8'h04;
  localparam logic [7:0] A_TESTOP  = 8'h08;
  localparam logic [7:0] A_TEXTP   = 8'h0c;
  localparam logic [7:0] A_TEXTN   = 8'h10;
  localparam logic [7:0] A_GNUM    = 8'h14;
  localparam logic [7:0] A_GDEN    = 8'h18;
  localparam logic [7:0] A_PAIR    = 8'h1c;
  localparam logic [7:0] A_SEL     = 8'h20;
  localparam logic [7:0] A_STAT    = 8'h24;
  localparam logic [7:0] A_MASK    = 8'h28;
  localparam logic [7:0] A_TMAX    = 8'h2c;
  localparam logic [7:0] A_FREQ    = 8'h30;
  localparam logic [7:0] A_SPEED   = 8'h34;
  localparam logic [7:0] A_ENC     = 8'h38;
  // reset values
  localparam logic [30:0] GEAR_RST = 31'h00000001;
  localparam logic [31:0] ENC_RST  = 32'h00800000;    // 2^23 counts
  localparam logic [31:0] ONE_SEC_CYC = CLK_HZ;
  // status bits
  localparam int ST_MULT = 0;
  localparam int ST_RANGE = 1;
  localparam int ST_CLAMP = 2;
  localparam int ST_PAIR = 3;
  typedef enum logic [2:0] {
    TLG_SEL_LIM1, TLG_SEL_LIM2, TLG_SEL_ESTOP, TLG_SEL_EXTP, TLG_SEL_EXTN
  } tlg_sel_t;
endpackage

// file: rtl/tlg_gear.sv
// tlg_gear: electronic gear pulse accumulator
// assumes one command pulse strobe per mclk at most
`timescale 1ns/1ps
module tlg_gear (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // gear setting
  input  wire logic [30:0] num,
  input  wire logic [30:0] den,
  // pulses
  input  wire logic        cmd_pulse,
  output logic             enc_pulse,
  output logic [15:0]      enc_per_cmd
);
  logic [32:0] acc;
  logic [32:0] next_acc;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_enc_pulse;

  always_comb begin
    next_acc = acc;
    next_cnt = cnt;
    next_enc_pulse = 1'b0;
    if (cmd_pulse) begin
      next_acc = acc + {2'h0, num};
      next_cnt = 16'h0000;
    end else if (acc >= {2'h0, den}) begin
      next_acc = acc - {2'h0, den};
      next_enc_pulse = 1'b1;
      if (cnt != 16'hffff) begin
        next_cnt = cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      acc <= 33'h000000000;
      cnt <= 16'h0000;
      enc_pulse <= 1'b0;
      enc_per_cmd <= 16'h0000;
    end else begin
      acc <= next_acc;
      cnt <= next_cnt;
      enc_pulse <= next_enc_pulse;
      enc_per_cmd <= cmd_pulse ? cnt : enc_per_cmd;
    end
  end
endmodule

// file: rtl/tlg_clamp.sv
// tlg_clamp: bounds a torque value to a limit
// combinational, used for requested torque only; settings use trq_bound
`timescale 1ns/1ps
module tlg_clamp (
  // values
  input  wire logic [9:0] value,
  input  wire logic [9:0] bound,
  output logic [9:0]      result,
  output logic            hit
);
  always_comb begin
    hit = value > bound;
    result = hit ? bound : value;
  end
endmodule

// file: sim/tlg_host_model.sv
// tlg_host_model: host issuing position command pulses
// assumes one mclk domain, fixed pulse spacing while enabled
`timescale 1ns/1ps
module tlg_host_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // pulse train control
  input  wire logic       enable,
  input  wire logic [7:0] period,
  // command output
  output logic            cmd_pulse
);
  logic [7:0] count;
  // one-cycle pulse every period cycles, no jitter
  always @(posedge mclk) begin
    if (reset || !enable) begin
      count     <= 8'h00;
      cmd_pulse <= 1'b0;
    end else begin
      count     <= (count == period - 8'h01) ? 8'h00 : count + 8'h01;
      cmd_pulse <= (count == period - 8'h01);
    end
  end
endmodule

// file: sim/tlg_assertions.sv
// tlg_checker: port-level checks of tlg_top
// assumes one mclk domain, synchronous active-high reset
`timescale 1ns/1ps
module tlg_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // motor and commands
  input wire logic [4:0]  motor_pair,
  input wire logic        cmd_pulse,
  input wire logic [9:0]  torque_req,
  // outputs
  input wire logic [9:0]  torque_cmd,
  input wire logic        enc_pulse,
  input wire logic        pulse_multiplication_error,
  input wire logic        irq
);
  logic clr;
  assign clr = wr && addr == tlg_pkg::A_STAT && wdata[0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_pair0; (motor_pair == 5'h00) [*5]; endsequence
  sequence s_pair20; (motor_pair == 5'h14) [*5]; endsequence
  sequence s_num_rd; $past(rd) && $past(addr) == tlg_pkg::A_GNUM; endsequence
  sequence s_max_rd; $past(rd) && $past(addr) == tlg_pkg::A_TMAX; endsequence
  a_cmd_below_req: assert property (torque_cmd <= $past(torque_req))
    else $error("torque above request");
  a_default_max: assert property (s_pair0 |-> torque_cmd <= 10'h12c)
    else $error("torque above default max");
  a_pair_low: assert property (s_pair20 |-> torque_cmd <= 10'h0f5)
    else $error("torque above pairing max");
  a_gear_range: assert property (s_num_rd |-> rdata != 0 && rdata <= 32'h40000000)
    else $error("gear numerator out of range");
  a_max_range: assert property (s_max_rd |-> rdata >= 32'hf5 && rdata <= 32'h15e)
    else $error("torque max out of range");
  a_no_enc_cmd: assert property (cmd_pulse |-> ##2 !enc_pulse)
    else $error("encoder pulse beside command pulse");
  a_err_sticky: assert property (pulse_multiplication_error && !clr && !$past(clr)
    |=> pulse_multiplication_error) else $error("error flag dropped");
  a_err_cause: assert property ($rose(pulse_multiplication_error)
    |-> $past(cmd_pulse) || $past(cmd_pulse, 2)) else $error("error without pulse");
endmodule
bind tlg_top tlg_checker u_chk (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .motor_pair(motor_pair), .cmd_pulse(cmd_pulse),
  .torque_req(torque_req), .torque_cmd(torque_cmd), .enc_pulse(enc_pulse),
  .pulse_multiplication_error(pulse_multiplication_error), .irq(irq));

// file: sim/torque_limit_and_gear_scaler_tb.sv
// torque_limit_and_gear_scaler_tb: register-level tests of tlg_top
// assumes tlg_checker bound and tlg_host_model as pulse source
`timescale 1ns/1ps
module torque_limit_and_gear_scaler_tb;
  logic        mclk, reset, wr, rd, pen, err, irq, cmd_pulse, enc_pulse;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rv;
  logic [4:0]  motor_pair;
  logic [9:0]  torque_req, torque_cmd;
  int          failures, check_count, ncmd, nenc, c0, e0;
  logic [4:0]  pc [8] = '{5'h00, 5'h01, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
  logic [9:0]  pm [8] = '{10'h12c, 10'h15e, 10'h108, 10'h119, 10'h0fb, 10'h128, 10'h0f5, 10'h0fa};
  logic [7:0]  la [5] = '{tlg_pkg::A_TLIM1, tlg_pkg::A_TLIM2, tlg_pkg::A_TESTOP,
                          tlg_pkg::A_TEXTP, tlg_pkg::A_TEXTN};
  tlg_top DUT (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .motor_pair(motor_pair), .cmd_pulse(cmd_pulse), .torque_req(torque_req),
    .torque_cmd(torque_cmd), .enc_pulse(enc_pulse), .pulse_multiplication_error(err),
    .irq(irq));
  tlg_host_model u_host (.mclk(mclk), .reset(reset), .enable(pen), .period(8'h14),
    .cmd_pulse(cmd_pulse));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ncmd <= ncmd + int'(cmd_pulse);
    nenc <= nenc + int'(enc_pulse);
  end
  task automatic stop_test();
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rreg(a);
    chk(rv, e);
  endtask
  task automatic rbit(input logic [7:0] a, input int b, input logic e);
    rreg(a);
    chk({31'h0, rv[b]}, {31'h0, e});
  endtask
  task automatic tchk(input logic [9:0] q, input logic [9:0] e);
    @(posedge mclk);
    torque_req <= q;
    repeat (2) @(posedge mclk);
    #1 chk({22'h0, torque_cmd}, {22'h0, e});
  endtask
  initial begin
    {reset, wr, rd, pen} = 4'h8;
    {addr, wdata, motor_pair, torque_req} = '0;
    {ncmd, nenc, failures, check_count} = '0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) rchk(la[i], 32'h12c);
    rchk(tlg_pkg::A_GNUM, 32'h1);
    rchk(tlg_pkg::A_ENC, 32'h00800000);
    rchk(8'hfc, 32'h0);
    rchk(tlg_pkg::A_FREQ, 32'h0);
    rchk(tlg_pkg::A_SPEED, 32'h0);
    wreg(tlg_pkg::A_ENC, 32'h0);
    rchk(tlg_pkg::A_ENC, 32'h00800000);
    wreg(tlg_pkg::A_GDEN, 32'h0);
    rchk(tlg_pkg::A_GDEN, 32'h1);
    wreg(tlg_pkg::A_SEL, 32'h7);
    rchk(tlg_pkg::A_SEL, 32'h0);
    wreg(la[0], 32'h190);
    rchk(la[0], 32'h12c);
    wreg(la[0], 32'h0);
    rchk(la[0], 32'h0);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      motor_pair <= pc[i];
      repeat (4) @(posedge mclk);
      rchk(tlg_pkg::A_TMAX, {22'h0, pm[i]});
    end
    @(posedge mclk);
    motor_pair <= 5'h01;
    for (int i = 0; i < 5; i++) wreg(la[i], 32'h15e - 32'(i) * 32'ha);
    for (int i = 0; i < 5; i++) begin
      wreg(tlg_pkg::A_SEL, 32'(i));
      tchk(10'h3ff, 10'h15e - 10'(i) * 10'ha);
    end
    tchk(10'h064, 10'h064);
    @(posedge mclk);
    motor_pair <= 5'h14;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 5; i++) rchk(la[i], 32'hf5);
    rchk(tlg_pkg::A_PAIR, 32'h14);
    rbit(tlg_pkg::A_STAT, tlg_pkg::ST_PAIR, 1'b1);
    tchk(10'h3ff, 10'h0f5);
    tchk(10'h000, 10'h000);
    wreg(tlg_pkg::A_GNUM, 32'h0);
    rchk(tlg_pkg::A_GNUM, 32'h1);
    wreg(tlg_pkg::A_GNUM, 32'hffffffff);
    rchk(tlg_pkg::A_GNUM, 32'h40000000);
    rbit(tlg_pkg::A_STAT, tlg_pkg::ST_RANGE, 1'b1);
    wreg(tlg_pkg::A_GNUM, 32'h8);
    wreg(tlg_pkg::A_STAT, 32'hf);
    rchk(tlg_pkg::A_STAT, 32'h0);
    @(posedge mclk);
    pen <= 1'b1;
    repeat (100) @(posedge mclk);
    pen <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk({31'h0, err}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wreg(tlg_pkg::A_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    #1 chk({31'h0, irq}, 32'h1);
    wreg(tlg_pkg::A_STAT, 32'h1);
    repeat (2) @(posedge mclk);
    #1 chk({30'h0, err, irq}, 32'h0);
    wreg(tlg_pkg::A_GNUM, 32'h1);
    wreg(tlg_pkg::A_GDEN, 32'h2);
    #1 c0 = ncmd;
    e0 = nenc;
    @(posedge mclk);
    pen <= 1'b1;
    repeat (200) @(posedge mclk);
    pen <= 1'b0;
    repeat (6) @(posedge mclk);
    #1 chk(32'(nenc - e0), 32'((ncmd - c0) / 2));
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    stop_test();
  end
endmodule
